// ### hw/fault_monitor_pkg.sv
// Constants shared by the service-channel fault and monitor logic
package fault_monitor_pkg;
  // Service command framing
  localparam logic [7:0] CHAN_NODE     = 8'hfe;
  localparam logic [1:0] SPACE_DIRECT  = 2'h3;
  localparam logic [1:0] SIZE_8        = 2'h0;
  localparam logic [1:0] SIZE_16       = 2'h1;
  localparam logic [1:0] SIZE_24       = 2'h2;
  localparam logic [1:0] SIZE_32       = 2'h3;
  // Direct command codes
  localparam logic [7:0] CMD_NULL      = 8'h00;
  localparam logic [7:0] CMD_FAULT_RD  = 8'h08;
  localparam logic [7:0] CMD_FAULT_CLR = 8'h09;
  localparam logic [7:0] CMD_MON_A     = 8'h0f;
  localparam logic [7:0] CMD_MON_B     = 8'h11;
  localparam logic [7:0] CMD_MON_C     = 8'h13;
  // Failure codes
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_BAD_ARG   = 8'h04;
  localparam logic [7:0] ERR_NEED_OFF  = 8'h0f;
  localparam logic [7:0] ERR_NEED_ON   = 8'h10;
  localparam logic [7:0] ERR_READ_ONLY = 8'h11;
  // Fault word layout
  localparam int FB_FAST_BREAKER = 15;
  localparam int FB_SLOW_BREAKER = 14;
  localparam int FB_BUS_OVERVOLT = 13;
  localparam int FB_AMP_OVERTEMP = 12;
  localparam int FB_ENCODER      = 11;
  localparam int FB_OVERSPEED    = 10;
  localparam int FB_MOTOR_TEMP   = 6;
  localparam int FB_HALL         = 5;
  localparam int FB_CHECKSUM     = 4;
  localparam int FB_LOGIC_DEV    = 2;
  localparam int FB_PHASE_FIND   = 1;
  localparam logic [15:0] FAULT_USED_MASK  = 16'hfc76;
  localparam logic [15:0] FAULT_STICKY_MASK = 16'h0014;
  localparam logic [15:0] FAULT_RESET      = 16'h0000;
  localparam logic [31:0] FAULT_COUNT      = 32'h0000_0001;
  // Warning word layout
  localparam int WB_BUS_UNDERVOLT = 0;
  localparam logic [15:0] WARN_USED_MASK = 16'h8c05;
  // Monitor table indices
  localparam logic [4:0] MON_IR       = 5'h00;
  localparam logic [4:0] MON_IS       = 5'h01;
  localparam logic [4:0] MON_IT       = 5'h02;
  localparam logic [4:0] MON_VR       = 5'h04;
  localparam logic [4:0] MON_VS       = 5'h05;
  localparam logic [4:0] MON_VT       = 5'h06;
  localparam logic [4:0] MON_VBUS     = 5'h07;
  localparam logic [4:0] MON_IRECT    = 5'h0a;
  localparam logic [4:0] MON_VEL      = 5'h0b;
  localparam logic [4:0] MON_POS_LO   = 5'h0e;
  localparam logic [4:0] MON_POS_HI   = 5'h0f;
  localparam logic [4:0] MON_DEM_A    = 5'h10;
  localparam logic [4:0] MON_DEM_B    = 5'h11;
  localparam logic [4:0] MON_PULSE    = 5'h12;
  localparam logic [4:0] MON_SINE     = 5'h13;
  localparam logic [4:0] MON_COSINE   = 5'h14;
  localparam logic [4:0] MON_LAST     = 5'h14;
  localparam logic [15:0] MON_ZERO    = 16'h0000;
  localparam int NUM_MON = 3;
endpackage

// ### hw/monitor_select.sv
// One monitor channel: table index to 16-bit quantity
`timescale 1ns/100ps
module monitor_select (
  // Selection
  input  wire logic [4:0]  sel,
  input  wire logic        interp_present,
  input  wire logic        interp_setup_mode,
  // Quantities
  input  wire logic [15:0] cur_r,
  input  wire logic [15:0] cur_s,
  input  wire logic [15:0] cur_t,
  input  wire logic [15:0] volt_r,
  input  wire logic [15:0] volt_s,
  input  wire logic [15:0] volt_t,
  input  wire logic [15:0] bus_volt,
  input  wire logic [15:0] rect_cur,
  input  wire logic [15:0] velocity,
  input  wire logic [31:0] shaft_pos,
  input  wire logic [15:0] demand_a,
  input  wire logic [15:0] demand_b,
  input  wire logic [15:0] position_pulse_output,
  input  wire logic [15:0] interp_sine,
  input  wire logic [15:0] interp_cosine,
  // Result
  output logic      [15:0] value
);
  import fault_monitor_pkg::*;

  wire interp_ok = interp_present;
  wire trig_ok   = interp_present & interp_setup_mode;

  always_comb begin
    case (sel)
      MON_IR:     value = cur_r;
      MON_IS:     value = cur_s;
      MON_IT:     value = cur_t;
      MON_VR:     value = volt_r;
      MON_VS:     value = volt_s;
      MON_VT:     value = volt_t;
      MON_VBUS:   value = bus_volt;
      MON_IRECT:  value = rect_cur;
      MON_VEL:    value = velocity;
      MON_POS_LO: value = shaft_pos[15:0];
      MON_POS_HI: value = shaft_pos[31:16];
      MON_DEM_A:  value = demand_a;
      MON_DEM_B:  value = demand_b;
      MON_PULSE:  value = interp_ok ? position_pulse_output : MON_ZERO;
      MON_SINE:   value = trig_ok ? interp_sine : MON_ZERO;
      MON_COSINE: value = trig_ok ? interp_cosine : MON_ZERO;
      default:    value = MON_ZERO;
    endcase
  end
endmodule

// ### hw/drive_fault_monitor_service.sv
// Service-channel fault word, monitor channels and command answers
`timescale 1ns/100ps
module drive_fault_monitor_service #(
  parameter int DRIVE_CHANNEL = 0
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // Service command from the node logic
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [7:0]           cmd_channel,
  input  wire logic [1:0]           cmd_space,
  input  wire logic [7:0]           cmd_addr,
  input  wire logic [1:0]           cmd_size,
  input  wire logic [31:0]          cmd_wdata,
  // Service answer
  output logic                      rsp_valid,
  output logic      [7:0]           rsp_error,
  output logic      [31:0]          rsp_rdata,
  // Amplifier state and fault conditions (from outside the clock domain)
  input  wire logic                 amp_enabled,
  input  wire logic [15:0]          fault_cond,
  input  wire logic                 bus_undervolt,
  // Monitor sources
  input  wire logic                 interp_present,
  input  wire logic                 interp_setup_mode,
  input  wire logic [15:0]          cur_r,
  input  wire logic [15:0]          cur_s,
  input  wire logic [15:0]          cur_t,
  input  wire logic [15:0]          volt_r,
  input  wire logic [15:0]          volt_s,
  input  wire logic [15:0]          volt_t,
  input  wire logic [15:0]          bus_volt,
  input  wire logic [15:0]          velocity,
  input  wire logic [31:0]          shaft_pos,
  input  wire logic [15:0]          demand_a,
  input  wire logic [15:0]          demand_b,
  input  wire logic [15:0]          position_pulse_output,
  input  wire logic [15:0]          interp_sine,
  input  wire logic [15:0]          interp_cosine,
  // Status
  output logic      [15:0]          composite_fault_word,
  output logic      [15:0]          warning_word,
  output logic      [15:0]          monitor_a,
  output logic      [15:0]          monitor_b,
  output logic      [15:0]          monitor_c
);
  import fault_monitor_pkg::*;

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? (~v + 16'h0001) : v;
  endfunction

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    case (sz)
      SIZE_8:  size_mask = 32'h0000_00ff;
      SIZE_16: size_mask = 32'h0000_ffff;
      SIZE_24: size_mask = 32'h00ff_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction

  // Two-stage synchronisers for asynchronous levels
  logic [15:0] fault_s1_q, fault_s2_q;
  logic        en_s1_q, en_s2_q, uv_s1_q, uv_s2_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_s1_q <= 16'h0000;
      fault_s2_q <= 16'h0000;
      en_s1_q    <= 1'b0;
      en_s2_q    <= 1'b0;
      uv_s1_q    <= 1'b0;
      uv_s2_q    <= 1'b0;
    end else if (clk_en) begin
      fault_s1_q <= fault_cond;
      fault_s2_q <= fault_s1_q;
      en_s1_q    <= amp_enabled;
      en_s2_q    <= en_s1_q;
      uv_s1_q    <= bus_undervolt;
      uv_s2_q    <= uv_s1_q;
    end
  end

  // Command decode
  wire        for_me    = (cmd_channel == 8'(DRIVE_CHANNEL)) && (cmd_space == SPACE_DIRECT);
  wire        take      = clk_en && cmd_valid && for_me;
  wire        is_fread  = cmd_addr == CMD_FAULT_RD;
  wire        is_fclr   = cmd_addr == CMD_FAULT_CLR;
  wire [1:0]  mon_ch    = (cmd_addr == CMD_MON_A) ? 2'h0 :
                          (cmd_addr == CMD_MON_B) ? 2'h1 : 2'h2;
  wire        is_mon    = (cmd_addr == CMD_MON_A) || (cmd_addr == CMD_MON_B) ||
                          (cmd_addr == CMD_MON_C);
  wire        is_null   = cmd_addr == CMD_NULL;
  wire [4:0]  new_index = cmd_wdata[4:0];
  wire        index_ok  = (cmd_wdata[31:5] == 27'h0) && (new_index <= MON_LAST);
  wire        fault_clr = take && cmd_write && is_fclr && !en_s2_q;

  // Answer code selection
  logic [7:0] err_d;
  always_comb begin
    if (!cmd_write || is_null)
      err_d = ERR_NONE;
    else if (is_fread)
      err_d = ERR_READ_ONLY;
    else if (is_fclr && en_s2_q)
      err_d = ERR_NEED_OFF;
    else if (is_mon && !index_ok)
      err_d = ERR_BAD_ARG;
    else if (!is_fclr && !is_mon)
      err_d = ERR_BAD_ARG;
    else
      err_d = ERR_NONE;
  end

  // Monitor index registers and selectors
  logic [4:0]  mon_sel_q [NUM_MON];
  logic [15:0] mon_val   [NUM_MON];
  logic [15:0] rect_cur;
  wire  [15:0] abs_r = abs16(cur_r);
  wire  [15:0] abs_s = abs16(cur_s);
  wire  [15:0] abs_t = abs16(cur_t);
  wire  [15:0] max_rs = (abs_r > abs_s) ? abs_r : abs_s;
  assign rect_cur = (max_rs > abs_t) ? max_rs : abs_t;

  genvar g;
  generate
    for (g = 0; g < NUM_MON; g++) begin : g_mon
      always_ff @(posedge sys_clk) begin
        if (!rst_n)
          mon_sel_q[g] <= MON_IR;
        else if (take && cmd_write && is_mon && index_ok && mon_ch == 2'(g))
          mon_sel_q[g] <= new_index;
      end
      monitor_select u_sel (
        .sel                   (mon_sel_q[g]),
        .interp_present        (interp_present),
        .interp_setup_mode     (interp_setup_mode),
        .cur_r                 (cur_r),
        .cur_s                 (cur_s),
        .cur_t                 (cur_t),
        .volt_r                (volt_r),
        .volt_s                (volt_s),
        .volt_t                (volt_t),
        .bus_volt              (bus_volt),
        .rect_cur              (rect_cur),
        .velocity              (velocity),
        .shaft_pos             (shaft_pos),
        .demand_a              (demand_a),
        .demand_b              (demand_b),
        .position_pulse_output (position_pulse_output),
        .interp_sine           (interp_sine),
        .interp_cosine         (interp_cosine),
        .value                 (mon_val[g])
      );
    end
  endgenerate

  // Fault word: set wins over clear; checksum and logic-device bits survive a clear
  logic [15:0] fault_q, fault_d;
  wire  [15:0] fault_set  = fault_s2_q & FAULT_USED_MASK;
  wire  [15:0] fault_keep = fault_clr ? (fault_q & FAULT_STICKY_MASK) : fault_q;
  assign fault_d = fault_keep | fault_set;

  // Warning word: undervoltage latches here, never in the fault word
  logic [15:0] warn_q;
  wire  [15:0] warn_set = {15'h0000, uv_s2_q} << WB_BUS_UNDERVOLT;

  // Read data selection
  logic [31:0] rdata_d;
  always_comb begin
    if (is_fread)
      rdata_d = {16'h0000, fault_q};
    else if (is_fclr)
      rdata_d = FAULT_COUNT;
    else if (is_mon)
      rdata_d = {27'h0, mon_sel_q[mon_ch]};
    else
      rdata_d = 32'h0000_0000;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_q <= FAULT_RESET;
      warn_q  <= 16'h0000;
    end else if (clk_en) begin
      fault_q <= fault_d;
      warn_q  <= (warn_q | warn_set) & WARN_USED_MASK;
    end
  end

  // Answer registers and status outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid            <= 1'b0;
      rsp_error            <= ERR_NONE;
      rsp_rdata            <= 32'h0000_0000;
      composite_fault_word <= FAULT_RESET;
      warning_word         <= 16'h0000;
      monitor_a            <= MON_ZERO;
      monitor_b            <= MON_ZERO;
      monitor_c            <= MON_ZERO;
    end else if (clk_en) begin
      rsp_valid            <= take;
      rsp_error            <= take ? err_d : ERR_NONE;
      rsp_rdata            <= (take && !cmd_write) ? (rdata_d & size_mask(cmd_size)) :
                              32'h0000_0000;
      composite_fault_word <= fault_d;
      warning_word         <= warn_q;
      monitor_a            <= mon_val[0];
      monitor_b            <= mon_val[1];
      monitor_c            <= mon_val[2];
    end
  end
endmodule

// ### test/drive_fault_monitor_service_checker.sv
// Concurrent checks on service answers and status words
`timescale 1ns/100ps
module drive_fault_monitor_service_checker #(
  parameter int DRIVE_CHANNEL = 0
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Service command and answer
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_channel,
  input wire logic [1:0]  cmd_space,
  input wire logic [7:0]  cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_error,
  // State
  input wire logic        amp_enabled,
  input wire logic [15:0] composite_fault_word,
  input wire logic [15:0] warning_word
);
  import fault_monitor_pkg::*;
  logic tk;
  logic clr;
  assign tk = clk_en && cmd_valid && cmd_channel == 8'(DRIVE_CHANNEL)
              && cmd_space == SPACE_DIRECT;
  assign clr = tk && cmd_write && cmd_addr == CMD_FAULT_CLR;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ro_write: assert property (
    tk && cmd_write && cmd_addr == CMD_FAULT_RD |=> rsp_valid && rsp_error == 8'h11)
    else $error("read-only write kept");
  chk_bad_index: assert property (
    tk && cmd_write && cmd_addr == CMD_MON_A && cmd_wdata > 32'd20 |=> rsp_error == 8'h04)
    else $error("bad index kept");
  chk_need_off: assert property (
    amp_enabled [*4] ##0 clr |=> rsp_error == 8'h0f)
    else $error("clear while enabled kept");
  chk_sticky_keep: assert property (
    ($past(composite_fault_word) & 16'h0014 & ~composite_fault_word) == 16'h0000)
    else $error("sticky fault dropped");
  chk_fault_hold: assert property (
    |($past(composite_fault_word) & ~composite_fault_word) |-> $past(clr) || $past(clr, 2))
    else $error("fault dropped unasked");
  chk_reserved_zero: assert property (
    (composite_fault_word & 16'h0389) == 16'h0000)
    else $error("reserved fault set");
  chk_not_addressed: assert property (
    clk_en && cmd_valid && !tk |=> !rsp_valid)
    else $error("foreign request answered");
  chk_warn_latch: assert property (
    $past(warning_word[0]) |-> warning_word[0])
    else $error("warning not latched");
  chk_answer_pulse: assert property (
    tk |=> rsp_valid)
    else $error("taken request not answered");
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(rsp_valid) && $stable(composite_fault_word))
    else $error("state moved while frozen");
endmodule
bind drive_fault_monitor_service drive_fault_monitor_service_checker #(
  .DRIVE_CHANNEL(DRIVE_CHANNEL)
) chk_i (
  .sys_clk, .rst_n, .clk_en, .cmd_valid, .cmd_write, .cmd_channel, .cmd_space,
  .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_error, .amp_enabled,
  .composite_fault_word, .warning_word
);

// ### test/host_model.sv
// Motion controller model issuing service-channel accesses
`timescale 1ns/100ps
module host_model (
  // Clock
  input  wire logic        sys_clk,
  // Service command
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_channel,
  output logic [1:0]       cmd_space,
  output logic [7:0]       cmd_addr,
  output logic [1:0]       cmd_size,
  output logic [31:0]      cmd_wdata,
  // Service answer
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_error,
  input  wire logic [31:0] rsp_rdata
);
  initial begin
    {cmd_valid, cmd_write, cmd_channel, cmd_space, cmd_addr, cmd_size, cmd_wdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] ch, input logic [1:0] sp,
                      input logic [7:0] ad, input logic [1:0] sz, input logic [31:0] wd,
                      output logic ok, output logic [7:0] er, output logic [31:0] rd);
    @(posedge sys_clk);
    {cmd_valid, cmd_write, cmd_channel} <= {1'b1, w, ch};
    {cmd_space, cmd_addr} <= {sp, ad};
    {cmd_size, cmd_wdata} <= {sz, wd};
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    // Address and write data, no longer qualified, show garbage
    cmd_addr <= ~ad;
    cmd_wdata <= ~wd;
    #1;
    {ok, er, rd} = {rsp_valid, rsp_error, rsp_rdata};
  endtask
endmodule

// ### test/drive_fault_monitor_service_tb.sv
// Self-checking bench for the service fault and monitor block
`timescale 1ns/100ps
module drive_fault_monitor_service_tb;
  import fault_monitor_pkg::*;
  logic        sys_clk, rst_n, clk_en, amp_enabled, bus_undervolt, cmd_valid, cmd_write;
  logic        interp_present, interp_setup_mode, rsp_valid, ok;
  logic [1:0]  cmd_space, cmd_size;
  logic [7:0]  cmd_channel, cmd_addr, rsp_error, er;
  logic [15:0] fault_cond, cur_r, cur_s, cur_t, volt_r, volt_s, volt_t, bus_volt;
  logic [15:0] velocity, demand_a, demand_b, position_pulse_output, interp_sine;
  logic [15:0] interp_cosine, composite_fault_word, warning_word;
  logic [15:0] monitor_a, monitor_b, monitor_c;
  logic [31:0] shaft_pos, cmd_wdata, rsp_rdata, rd;
  int          error_cnt, compares;
  drive_fault_monitor_service uut (
    .sys_clk, .rst_n, .clk_en, .cmd_valid, .cmd_write, .cmd_channel, .cmd_space,
    .cmd_addr, .cmd_size, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata,
    .amp_enabled, .fault_cond, .bus_undervolt, .interp_present, .interp_setup_mode,
    .cur_r, .cur_s, .cur_t, .volt_r, .volt_s, .volt_t, .bus_volt, .velocity,
    .shaft_pos, .demand_a, .demand_b, .position_pulse_output, .interp_sine,
    .interp_cosine, .composite_fault_word, .warning_word, .monitor_a, .monitor_b,
    .monitor_c
  );
  host_model hm (
    .sys_clk, .cmd_valid, .cmd_write, .cmd_channel, .cmd_space, .cmd_addr,
    .cmd_size, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    hm.xfer(w, 8'h00, SPACE_DIRECT, a, SIZE_32, d, ok, er, rd);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic [15:0] exp_mon(input int i);
    case (i)
      0: return cur_r;
      1: return cur_s;
      2: return cur_t;
      4: return volt_r;
      5: return volt_s;
      6: return volt_t;
      7: return bus_volt;
      10: return 16'h0010;
      11: return velocity;
      14: return shaft_pos[15:0];
      15: return shaft_pos[31:16];
      16: return demand_a;
      17: return demand_b;
      18: return interp_present ? position_pulse_output : 16'h0000;
      19: return (interp_present && interp_setup_mode) ? interp_sine : 16'h0000;
      20: return (interp_present && interp_setup_mode) ? interp_cosine : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test;
  end
  initial begin
    {rst_n, clk_en, amp_enabled, bus_undervolt} = 4'b0100;
    {interp_present, interp_setup_mode, fault_cond} = {2'b11, 16'h0000};
    {cur_r, cur_s, cur_t} = {16'h0005, 16'hfff0, 16'h0003};
    {volt_r, volt_s, volt_t, bus_volt} = {16'h1104, 16'h1105, 16'h1106, 16'h1107};
    {velocity, demand_a, demand_b} = {16'h110b, 16'h1110, 16'h1111};
    {position_pulse_output, interp_sine, interp_cosine} = {16'h1112, 16'h1113, 16'h1114};
    {shaft_pos, error_cnt, compares} = {32'h2f0e_1e0e, 64'h0};
    cyc(16);
    rst_n <= 1'b1;
    fault_cond <= 16'hffff;
    bus_undervolt <= 1'b1;
    cyc(6);
    fault_cond <= 16'h0000;
    bus_undervolt <= 1'b0;
    cyc(6);
    op(1'b0, CMD_FAULT_RD, 32'h0);
    chk(rd, 32'h0000_fc76, "fault word");
    chk(warning_word, 16'h0001, "warning");
    hm.xfer(1'b0, 8'h00, SPACE_DIRECT, CMD_FAULT_RD, SIZE_8, 32'h0, ok, er, rd);
    chk(rd, 32'h0000_0076, "byte read");
    hm.xfer(1'b0, CHAN_NODE, SPACE_DIRECT, CMD_FAULT_RD, SIZE_32, 32'h0, ok, er, rd);
    chk(ok, 1'b0, "node channel");
    hm.xfer(1'b0, 8'h00, 2'h0, CMD_FAULT_RD, SIZE_32, 32'h0, ok, er, rd);
    chk(ok, 1'b0, "data space");
    op(1'b0, CMD_FAULT_CLR, 32'h0);
    chk(rd, 32'h1, "fault count");
    op(1'b1, CMD_FAULT_RD, 32'h0);
    chk(er, 8'h11, "read-only");
    cyc(1);
    amp_enabled <= 1'b1;
    cyc(4);
    op(1'b1, CMD_FAULT_CLR, 32'h0);
    chk(er, 8'h0f, "need off");
    cyc(1);
    amp_enabled <= 1'b0;
    cyc(4);
    op(1'b1, CMD_FAULT_CLR, 32'h0);
    chk(er, 8'h00, "clear");
    op(1'b0, CMD_FAULT_RD, 32'h0);
    chk(rd, 32'h0000_0014, "sticky");
    chk(composite_fault_word, 16'h0014, "sticky word");
    op(1'b1, CMD_MON_A, 32'd21);
    chk(er, 8'h04, "index 21");
    op(1'b1, CMD_MON_A, 32'h0000_0105);
    chk(er, 8'h04, "high bits");
    op(1'b0, CMD_MON_A, 32'h0);
    chk(rd, 32'h0, "index kept");
    op(1'b1, 8'h20, 32'h0);
    chk(er, 8'h04, "unknown code");
    for (int i = 0; i <= 20; i++) begin
      op(1'b1, CMD_MON_A, 32'(i));
      cyc(2);
      #1;
      chk(monitor_a, exp_mon(i), "monitor");
    end
    cyc(1);
    interp_setup_mode <= 1'b0;
    cyc(3);
    #1;
    chk(monitor_a, 16'h0000, "no setup");
    cyc(1);
    interp_present <= 1'b0;
    op(1'b1, CMD_MON_A, 32'd18);
    cyc(2);
    #1;
    chk(monitor_a, 16'h0000, "no option");
    cyc(1);
    interp_present <= 1'b1;
    op(1'b1, CMD_MON_B, 32'd14);
    op(1'b1, CMD_MON_C, 32'd15);
    cyc(2);
    #1;
    chk(monitor_b, shaft_pos[15:0], "pos low");
    chk(monitor_c, shaft_pos[31:16], "pos high");
    op(1'b0, CMD_MON_B, 32'h0);
    chk(rd, 32'd14, "index b");
    // Clock enable low: request ignored, index frozen
    cyc(1);
    clk_en <= 1'b0;
    op(1'b1, CMD_MON_B, 32'd5);
    chk(ok, 1'b0, "frozen");
    cyc(1);
    clk_en <= 1'b1;
    op(1'b0, CMD_MON_B, 32'h0);
    chk(rd, 32'd14, "index frozen");
    // Mid-run reset removes even the sticky faults
    cyc(1);
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    op(1'b0, CMD_FAULT_RD, 32'h0);
    chk(rd, 32'h0, "reset clears sticky");
    chk(warning_word, 16'h0000, "reset warning");
    op(1'b0, CMD_MON_B, 32'h0);
    chk(rd, 32'h0, "reset index");
    stop_test;
  end
endmodule
